// ---- hdl/tcc_channel.sv ----
// One capture / compare / PWM channel of the pulse timer module
//
// Behaviour
// - Capture mode sets the event flag on the selected pin edge.
// - Compare or edge PWM mode sets the flag on counter equal value.
// - Center PWM sets the flag on every match, both pulse edges.
// - Interrupt request while event flag and interrupt enable both set.
// - Flag clears only after read of control with flag set, then write 0.
// - A new event during the clear sequence restarts it; flag stays.
// - Writing 1 to the flag does nothing; reset clears it.
// - Interrupt enable is read/write, reset to 0; 1 enables requests.
// - Without center mode, mode select B at 1 gives edge PWM.
// - Without center mode and B at 0, A picks capture or compare.
// - Edge/level select 00 releases the pin in every mode.
// - Capture edge: 01 rising, 10 falling, 11 either.
// - Compare pin action: 00 none, 01 toggle, 10 clear, 11 set.
// - Edge PWM: 10 high-true cleared on match; X1 low-true set on match.
// - Center PWM: 10 cleared on up match; X1 set on up match.
// - Capture mode latches the counter into the value register.
// - Value is read/write as high and low byte, reset to zero.
// - Capture mode: reading one byte freezes both until the other.
// - Any control write releases the capture read buffer.
// - Compare/PWM: value updates as one word after both byte writes.
// - A control write discards a half-written compare value.
// - Shared center select forces center PWM; else per-channel modes.
//
// The register addresses and the strobed register port were decided locally.
module tcc_channel (
    input wire logic ref_clk,
    input wire logic reset_n,
    input tcc_pkg::tcc_bus_req_t bus_req,
    output logic [7:0] bus_rdata,
    input tcc_pkg::tcc_timer_t timer,
    input wire logic chan_pin_in,
    output logic chan_pin_out,
    output logic chan_pin_oe,
    output logic channel_irq
);
    import tcc_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic channel_event_flag;
    logic channel_irq_enable;
    logic mode_select_b;
    logic mode_select_a;
    logic [1:0] edge_level_select;
    logic clear_armed;
    logic [15:0] channel_value;
    logic [15:0] read_buffer;
    logic read_latched;
    logic [7:0] write_buf_high;
    logic [7:0] write_buf_low;
    logic high_written;
    logic low_written;
    logic pin_sync1;
    logic pin_sync2;
    logic pin_prev;
    logic edge_pending;
    logic out_bit;
    tcc_mode_t mode;
    logic pin_used;
    logic edge_now;
    logic capture_event;
    logic match_event;
    logic channel_event;
    logic sc_write;
    logic sc_read;
    logic vh_write;
    logic vl_write;
    logic vh_read;
    logic vl_read;
    logic [7:0] next_rdata;
    logic read_first_high;

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    // Mode from shared center select and the two mode select bits
    function automatic tcc_mode_t tcc_decode_mode(input logic center,
                                                  input logic msb,
                                                  input logic msa);
        tcc_mode_t m;
        m = TCC_MODE_CAPTURE;
        if (center) begin
            m = TCC_MODE_CENTER_PWM;
        end else if (msb) begin
            m = TCC_MODE_EDGE_PWM;
        end else if (msa) begin
            m = TCC_MODE_COMPARE;
        end
        return m;
    endfunction : tcc_decode_mode

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    assign mode = tcc_decode_mode(timer.center_align_select,
                                  mode_select_b, mode_select_a);
    assign pin_used = (edge_level_select != TCC_ELS_NONE);

    always_comb begin
        sc_write = 1'b0;
        sc_read = 1'b0;
        vh_write = 1'b0;
        vl_write = 1'b0;
        vh_read = 1'b0;
        vl_read = 1'b0;
        if (bus_req.addr == TCC_OFS_STATUS_CONTROL) begin
            sc_write = bus_req.wr;
            sc_read = bus_req.rd;
        end else if (bus_req.addr == TCC_OFS_VALUE_HIGH) begin
            vh_write = bus_req.wr;
            vh_read = bus_req.rd;
        end else if (bus_req.addr == TCC_OFS_VALUE_LOW) begin
            vl_write = bus_req.wr;
            vl_read = bus_req.rd;
        end
    end

    // ------------------------------------------------------------
    // Pin synchroniser and edge detection
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            pin_sync1 <= 1'b0;
            pin_sync2 <= 1'b0;
            pin_prev <= 1'b0;
        end else begin
            pin_sync1 <= chan_pin_in;
            pin_sync2 <= pin_sync1;
            pin_prev <= pin_sync2;
        end
    end

    always_comb begin
        edge_now = 1'b0;
        if (mode == TCC_MODE_CAPTURE) begin
            case (edge_level_select)
                TCC_ELS_RISE: begin
                    edge_now = pin_sync2 & ~pin_prev;
                end
                TCC_ELS_FALL: begin
                    edge_now = ~pin_sync2 & pin_prev;
                end
                TCC_ELS_BOTH: begin
                    edge_now = pin_sync2 ^ pin_prev;
                end
                default: begin
                    edge_now = 1'b0;
                end
            endcase
        end
    end

    // Edge seen between ticks waits for the next tick
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            edge_pending <= 1'b0;
        end else if (timer.count_tick || mode != TCC_MODE_CAPTURE) begin
            edge_pending <= 1'b0;
        end else if (edge_now) begin
            edge_pending <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Channel events
    // ------------------------------------------------------------
    assign capture_event = timer.count_tick && mode == TCC_MODE_CAPTURE
                           && (edge_now || edge_pending);
    assign match_event = timer.count_tick && mode != TCC_MODE_CAPTURE
                         && timer.count_value == channel_value;
    assign channel_event = capture_event | match_event;

    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            channel_irq_enable <= TCC_RST_CONTROL[TCC_BIT_IRQ_ENABLE];
            mode_select_b <= TCC_RST_CONTROL[TCC_BIT_MODE_B];
            mode_select_a <= TCC_RST_CONTROL[TCC_BIT_MODE_A];
            edge_level_select <=
                TCC_RST_CONTROL[TCC_BIT_ELS_HI:TCC_BIT_ELS_LO];
        end else if (sc_write) begin
            channel_irq_enable <= bus_req.wdata[TCC_BIT_IRQ_ENABLE];
            mode_select_b <= bus_req.wdata[TCC_BIT_MODE_B];
            mode_select_a <= bus_req.wdata[TCC_BIT_MODE_A];
            edge_level_select <=
                bus_req.wdata[TCC_BIT_ELS_HI:TCC_BIT_ELS_LO];
        end
    end

    // ------------------------------------------------------------
    // Event flag and its two-step clear
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            clear_armed <= 1'b0;
        end else if (channel_event) begin
            clear_armed <= 1'b0;
        end else if (sc_write) begin
            clear_armed <= 1'b0;
        end else if (sc_read && channel_event_flag) begin
            clear_armed <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            channel_event_flag <= TCC_RST_CONTROL[TCC_BIT_EVENT_FLAG];
        end else if (channel_event) begin
            channel_event_flag <= 1'b1;
        end else if (sc_write && clear_armed
                     && !bus_req.wdata[TCC_BIT_EVENT_FLAG]) begin
            channel_event_flag <= 1'b0;
        end
    end

    assign channel_irq = channel_event_flag & channel_irq_enable;

    // ------------------------------------------------------------
    // Compare write buffer
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            write_buf_high <= TCC_RST_VALUE[15:8];
            write_buf_low <= TCC_RST_VALUE[7:0];
            high_written <= 1'b0;
            low_written <= 1'b0;
        end else if (sc_write || mode == TCC_MODE_CAPTURE) begin
            high_written <= 1'b0;
            low_written <= 1'b0;
        end else if (vh_write) begin
            write_buf_high <= bus_req.wdata;
            high_written <= ~low_written;
            low_written <= 1'b0;
        end else if (vl_write) begin
            write_buf_low <= bus_req.wdata;
            low_written <= ~high_written;
            high_written <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Channel value register
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            channel_value <= TCC_RST_VALUE;
        end else if (capture_event) begin
            channel_value <= timer.count_value;
        end else if (mode == TCC_MODE_CAPTURE) begin
            if (vh_write) begin
                channel_value[15:8] <= bus_req.wdata;
            end else if (vl_write) begin
                channel_value[7:0] <= bus_req.wdata;
            end
        end else if (!sc_write && vh_write && low_written) begin
            channel_value <= {bus_req.wdata, write_buf_low};
        end else if (!sc_write && vl_write && high_written) begin
            channel_value <= {write_buf_high, bus_req.wdata};
        end
    end

    // ------------------------------------------------------------
    // Capture read buffer
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            read_buffer <= TCC_RST_VALUE;
            read_latched <= 1'b0;
        end else if (sc_write || mode != TCC_MODE_CAPTURE) begin
            read_latched <= 1'b0;
        end else if (vh_read || vl_read) begin
            if (!read_latched) begin
                read_buffer <= channel_value;
                read_latched <= 1'b1;
            end else if (vh_read != read_first_high) begin
                read_latched <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            read_first_high <= 1'b0;
        end else if (!read_latched && (vh_read || vl_read)) begin
            read_first_high <= vh_read;
        end
    end

    // ------------------------------------------------------------
    // Read data, one cycle after the strobe
    // ------------------------------------------------------------
    always_comb begin
        next_rdata = TCC_RST_RDATA;
        if (sc_read) begin
            next_rdata[TCC_BIT_EVENT_FLAG] = channel_event_flag;
            next_rdata[TCC_BIT_IRQ_ENABLE] = channel_irq_enable;
            next_rdata[TCC_BIT_MODE_B] = mode_select_b;
            next_rdata[TCC_BIT_MODE_A] = mode_select_a;
            next_rdata[TCC_BIT_ELS_HI:TCC_BIT_ELS_LO] = edge_level_select;
        end else if (vh_read) begin
            next_rdata = read_latched ? read_buffer[15:8]
                                      : channel_value[15:8];
        end else if (vl_read) begin
            next_rdata = read_latched ? read_buffer[7:0]
                                      : channel_value[7:0];
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            bus_rdata <= TCC_RST_RDATA;
        end else begin
            bus_rdata <= next_rdata;
        end
    end

    // ------------------------------------------------------------
    // Pin output
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            out_bit <= 1'b0;
        end else if (timer.count_tick && pin_used) begin
            case (mode)
                TCC_MODE_COMPARE: begin
                    if (match_event) begin
                        case (edge_level_select)
                            TCC_ELS_TOGGLE: begin
                                out_bit <= ~out_bit;
                            end
                            TCC_ELS_CLEAR: begin
                                out_bit <= 1'b0;
                            end
                            TCC_ELS_SET: begin
                                out_bit <= 1'b1;
                            end
                            default: begin
                                out_bit <= out_bit;
                            end
                        endcase
                    end
                end
                TCC_MODE_EDGE_PWM: begin
                    if (match_event) begin
                        out_bit <= edge_level_select[0];
                    end else if (timer.overflow) begin
                        out_bit <= ~edge_level_select[0];
                    end
                end
                TCC_MODE_CENTER_PWM: begin
                    if (match_event) begin
                        out_bit <= timer.count_up ? edge_level_select[0]
                                   : ~edge_level_select[0];
                    end
                end
                default: begin
                    out_bit <= out_bit;
                end
            endcase
        end
    end

    assign chan_pin_out = out_bit;
    assign chan_pin_oe = pin_used && mode != TCC_MODE_CAPTURE;

endmodule : tcc_channel

// ---- hdl/tcc_pkg.sv ----
// Package: register map, field layout, encodings and carriers of the channel
package tcc_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [1:0] TCC_OFS_STATUS_CONTROL = 2'h0;
    localparam logic [1:0] TCC_OFS_VALUE_HIGH = 2'h1;
    localparam logic [1:0] TCC_OFS_VALUE_LOW = 2'h2;

    // ------------------------------------------------------------
    // Field positions of channel_status_control
    // ------------------------------------------------------------
    localparam int TCC_BIT_EVENT_FLAG = 7;
    localparam int TCC_BIT_IRQ_ENABLE = 6;
    localparam int TCC_BIT_MODE_B = 5;
    localparam int TCC_BIT_MODE_A = 4;
    localparam int TCC_BIT_ELS_HI = 3;
    localparam int TCC_BIT_ELS_LO = 2;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] TCC_RST_CONTROL = 8'h00;
    localparam logic [15:0] TCC_RST_VALUE = 16'h0000;
    localparam logic [7:0] TCC_RST_RDATA = 8'h00;

    // ------------------------------------------------------------
    // Edge / level select encodings
    // ------------------------------------------------------------
    localparam logic [1:0] TCC_ELS_NONE = 2'h0;
    localparam logic [1:0] TCC_ELS_RISE = 2'h1;
    localparam logic [1:0] TCC_ELS_FALL = 2'h2;
    localparam logic [1:0] TCC_ELS_BOTH = 2'h3;
    localparam logic [1:0] TCC_ELS_TOGGLE = 2'h1;
    localparam logic [1:0] TCC_ELS_CLEAR = 2'h2;
    localparam logic [1:0] TCC_ELS_SET = 2'h3;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        TCC_MODE_CAPTURE,
        TCC_MODE_COMPARE,
        TCC_MODE_EDGE_PWM,
        TCC_MODE_CENTER_PWM
    } tcc_mode_t;

    typedef struct packed {
        logic [1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } tcc_bus_req_t;

    typedef struct packed {
        logic [15:0] count_value;
        logic count_tick;
        logic count_up;
        logic overflow;
        logic center_align_select;
    } tcc_timer_t;

endpackage : tcc_pkg

// ---- tb/tcc_channel_sva.sv ----
// Port checker for one timer capture/compare channel
module tcc_channel_sva (
    input logic ref_clk,
    input logic reset_n,
    input tcc_pkg::tcc_bus_req_t bus_req,
    input logic [7:0] bus_rdata,
    input tcc_pkg::tcc_timer_t timer,
    input logic chan_pin_in,
    input logic chan_pin_out,
    input logic chan_pin_oe,
    input logic channel_irq
);
    timeunit 1ns;
    timeprecision 1ns;
    import tcc_pkg::*;

    logic ctrl_wr;
    logic ctrl_rd;
    assign ctrl_wr = bus_req.wr && bus_req.addr == TCC_OFS_STATUS_CONTROL;
    assign ctrl_rd = bus_req.rd && bus_req.addr == TCC_OFS_STATUS_CONTROL;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    // ------------------------------------------------------------
    // Bus side
    // ------------------------------------------------------------
    rdata_idle_a: assert property (
        !bus_req.rd |=> bus_rdata == 8'h00)
        else $error("read data not zero outside a read");
    unmapped_read_a: assert property (
        bus_req.rd && bus_req.addr == 2'h3 |=> bus_rdata == 8'h00)
        else $error("unmapped read not zero");
    ctrl_spare_a: assert property (
        ctrl_rd |=> bus_rdata[1:0] == 2'h0)
        else $error("control spare bits not zero");

    // ------------------------------------------------------------
    // Interrupt and pin
    // ------------------------------------------------------------
    irq_match_a: assert property (
        ctrl_rd && !timer.count_tick |=>
            channel_irq == (bus_rdata[7] && bus_rdata[6]))
        else $error("irq differs from flag and enable");
    irq_mask_a: assert property (
        ctrl_wr && !bus_req.wdata[6] |=> !channel_irq)
        else $error("irq high with enable cleared");
    irq_rise_a: assert property (
        $rose(channel_irq) |-> $past(timer.count_tick) || $past(ctrl_wr))
        else $error("irq rose without event or enable");
    irq_fall_a: assert property (
        $fell(channel_irq) |-> $past(ctrl_wr))
        else $error("irq fell without control write");
    pin_release_a: assert property (
        ctrl_wr && bus_req.wdata[3:2] == TCC_ELS_NONE |=> !chan_pin_oe)
        else $error("pin driven with select 00");
    capture_oe_a: assert property (
        ctrl_wr && bus_req.wdata[5:4] == 2'h0
            ##1 !timer.center_align_select |-> !chan_pin_oe)
        else $error("pin driven in capture mode");
    compare_oe_a: assert property (
        ctrl_wr && bus_req.wdata[5:4] == 2'h1 && bus_req.wdata[3:2] != 2'h0
            ##1 !timer.center_align_select |-> chan_pin_oe)
        else $error("pin not driven in compare mode");
    pin_hold_a: assert property (
        $changed(chan_pin_out) |-> $past(timer.count_tick))
        else $error("pin output changed without tick");
endmodule : tcc_channel_sva

bind tcc_channel tcc_channel_sva u_tcc_channel_sva (
    .ref_clk(ref_clk), .reset_n(reset_n), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .timer(timer), .chan_pin_in(chan_pin_in),
    .chan_pin_out(chan_pin_out), .chan_pin_oe(chan_pin_oe),
    .channel_irq(channel_irq));

// ---- tb/tcc_pin_source.sv ----
// Signal source and load on the channel pin
module tcc_pin_source (
    input logic src_en,
    input logic src_level,
    input logic chan_pin_out,
    input logic chan_pin_oe,
    output logic pin_level
);
    timeunit 1ns;
    timeprecision 1ns;

    // Channel drive wins, then the enabled source; a pin driven by neither rests on its pull-up
    always_comb begin
        if (chan_pin_oe) begin
            pin_level = chan_pin_out;
        end else if (src_en) begin
            pin_level = src_level;
        end else begin
            pin_level = 1'b1;
        end
    end
endmodule : tcc_pin_source

// ---- tb/test_timer_channel_capture_compare.sv ----
// Self-checking bench for one timer capture/compare channel
module test_timer_channel_capture_compare;
    timeunit 1ns;
    timeprecision 1ns;
    import tcc_pkg::*;

    typedef struct packed {
        logic [7:0] ctrl;
        logic center;
        logic up2;
        logic [15:0] cnt2;
        logic ovf2;
        logic exp1;
        logic exp2;
        logic oe;
    } tcc_row_t;

    logic ref_clk;
    logic reset_n;
    tcc_bus_req_t bus_req;
    logic [7:0] bus_rdata;
    tcc_timer_t timer;
    logic pin_level;
    logic src_level;
    logic src_en;
    logic chan_pin_out;
    logic chan_pin_oe;
    logic channel_irq;
    logic [7:0] rdata;
    logic [7:0] cfg;
    int errors;
    int cmp_count;

    tcc_row_t rows [10] = '{
        '{8'h1C, 1'b0, 1'b1, 16'h0123, 1'b0, 1'b1, 1'b1, 1'b1},
        '{8'h10, 1'b0, 1'b1, 16'h0123, 1'b0, 1'b1, 1'b1, 1'b0},
        '{8'h14, 1'b0, 1'b1, 16'h0123, 1'b0, 1'b0, 1'b1, 1'b1},
        '{8'h18, 1'b0, 1'b1, 16'h0123, 1'b0, 1'b0, 1'b0, 1'b1},
        '{8'h28, 1'b0, 1'b1, 16'h0000, 1'b1, 1'b0, 1'b1, 1'b1},
        '{8'h24, 1'b0, 1'b1, 16'h0000, 1'b1, 1'b1, 1'b0, 1'b1},
        '{8'h38, 1'b0, 1'b1, 16'h0000, 1'b1, 1'b0, 1'b1, 1'b1},
        '{8'h08, 1'b1, 1'b0, 16'h0123, 1'b0, 1'b0, 1'b1, 1'b1},
        '{8'h34, 1'b1, 1'b0, 16'h0123, 1'b0, 1'b1, 1'b0, 1'b1},
        '{8'h0C, 1'b1, 1'b0, 16'h0123, 1'b0, 1'b1, 1'b0, 1'b1}
    };

    tcc_channel u_tcc_channel (
        .ref_clk(ref_clk), .reset_n(reset_n), .bus_req(bus_req),
        .bus_rdata(bus_rdata), .timer(timer), .chan_pin_in(pin_level),
        .chan_pin_out(chan_pin_out), .chan_pin_oe(chan_pin_oe),
        .channel_irq(channel_irq));

    tcc_pin_source u_tcc_pin_source (
        .src_en(src_en), .src_level(src_level), .chan_pin_out(chan_pin_out),
        .chan_pin_oe(chan_pin_oe), .pin_level(pin_level));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic wrap_up();
        $display("errors %0d comparisons %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : wrap_up

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask : chk8

    task automatic chk_bit(input logic got, input logic exp);
        chk8({7'h00, got}, {7'h00, exp});
    endtask : chk_bit

    task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        bus_req.wr <= 1'b1;
        bus_req.addr <= a;
        bus_req.wdata <= d;
        @(posedge ref_clk);
        bus_req.wr <= 1'b0;
        #1;
    endtask : wr_reg

    task automatic rd_reg(input logic [1:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        bus_req.rd <= 1'b1;
        bus_req.addr <= a;
        @(posedge ref_clk);
        bus_req.rd <= 1'b0;
        #1;
        d = bus_rdata;
    endtask : rd_reg

    task automatic rd_chk(input logic [1:0] a, input logic [7:0] exp);
        rd_reg(a, rdata);
        chk8(rdata, exp);
    endtask : rd_chk

    task automatic clear_flag(input logic [7:0] c);
        rd_reg(TCC_OFS_STATUS_CONTROL, rdata);
        wr_reg(TCC_OFS_STATUS_CONTROL, c & 8'h7F);
    endtask : clear_flag

    task automatic tick(input logic [15:0] c, input logic up, input logic ovf);
        @(posedge ref_clk);
        timer.count_tick <= 1'b1;
        timer.count_value <= c;
        timer.count_up <= up;
        timer.overflow <= ovf;
        @(posedge ref_clk);
        timer.count_tick <= 1'b0;
        timer.overflow <= 1'b0;
        #1;
    endtask : tick

    task automatic set_pin(input logic lvl);
        @(posedge ref_clk);
        src_level <= lvl;
        repeat (4) @(posedge ref_clk);
    endtask : set_pin

    // ------------------------------------------------------------
    // Clock, watchdog and sequence
    // ------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    initial begin
        repeat (5000) @(posedge ref_clk);
        errors++;
        wrap_up();
    end

    initial begin
        reset_n = 1'b0;
        bus_req = '0;
        timer = '0;
        src_level = 1'b0;
        src_en = 1'b1;
        errors = 0;
        cmp_count = 0;
        repeat (10) @(posedge ref_clk);
        reset_n <= 1'b1;
        foreach (rows[i]) begin
            @(posedge ref_clk);
            timer.center_align_select <= rows[i].center;
            wr_reg(TCC_OFS_STATUS_CONTROL, rows[i].ctrl);
            clear_flag(rows[i].ctrl);
            wr_reg(TCC_OFS_VALUE_HIGH, 8'h01);
            wr_reg(TCC_OFS_VALUE_LOW, 8'h23);
            tick(16'h0123, 1'b1, 1'b0);
            chk_bit(chan_pin_out, rows[i].exp1);
            tick(rows[i].cnt2, rows[i].up2, rows[i].ovf2);
            chk_bit(chan_pin_out, rows[i].exp2);
            chk_bit(chan_pin_oe, rows[i].oe);
            rd_reg(TCC_OFS_STATUS_CONTROL, rdata);
            chk8(rdata & 8'h80, 8'h80);
        end
        @(posedge ref_clk);
        timer.center_align_select <= 1'b0;
        for (int e = 0; e < 4; e++) begin
            cfg = {4'h0, e[1:0], 2'h0};
            wr_reg(TCC_OFS_STATUS_CONTROL, cfg);
            clear_flag(cfg);
            set_pin(1'b1);
            tick({8'hAB, cfg}, 1'b1, 1'b0);
            rd_chk(TCC_OFS_STATUS_CONTROL, {e[0], cfg[6:0]});
            clear_flag(cfg);
            set_pin(1'b0);
            tick({8'hCD, cfg}, 1'b1, 1'b0);
            rd_chk(TCC_OFS_STATUS_CONTROL, {e[1], cfg[6:0]});
        end
        rd_chk(TCC_OFS_VALUE_LOW, 8'h0C);
        set_pin(1'b1);
        tick(16'h1234, 1'b1, 1'b0);
        rd_chk(TCC_OFS_VALUE_HIGH, 8'hCD);
        rd_chk(TCC_OFS_VALUE_HIGH, 8'h12);
        set_pin(1'b0);
        tick(16'h5678, 1'b1, 1'b0);
        wr_reg(TCC_OFS_STATUS_CONTROL, 8'h0C);
        rd_chk(TCC_OFS_VALUE_LOW, 8'h78);
        wr_reg(TCC_OFS_STATUS_CONTROL, 8'h50);
        clear_flag(8'h50);
        wr_reg(TCC_OFS_VALUE_HIGH, 8'h12);
        wr_reg(TCC_OFS_VALUE_LOW, 8'h34);
        wr_reg(TCC_OFS_VALUE_HIGH, 8'h56);
        tick(16'h1234, 1'b1, 1'b0);
        chk_bit(channel_irq, 1'b1);
        wr_reg(TCC_OFS_STATUS_CONTROL, 8'hD0);
        wr_reg(TCC_OFS_VALUE_LOW, 8'h78);
        rd_chk(TCC_OFS_VALUE_HIGH, 8'h12);
        wr_reg(TCC_OFS_VALUE_HIGH, 8'h56);
        rd_chk(TCC_OFS_VALUE_HIGH, 8'h56);
        rd_chk(TCC_OFS_VALUE_LOW, 8'h78);
        rd_chk(TCC_OFS_STATUS_CONTROL, 8'hD0);
        tick(16'h5678, 1'b1, 1'b0);
        wr_reg(TCC_OFS_STATUS_CONTROL, 8'h50);
        chk_bit(channel_irq, 1'b1);
        clear_flag(8'h50);
        chk_bit(channel_irq, 1'b0);
        wr_reg(TCC_OFS_STATUS_CONTROL, 8'h10);
        tick(16'h5678, 1'b1, 1'b0);
        chk_bit(channel_irq, 1'b0);
        wr_reg(TCC_OFS_STATUS_CONTROL, 8'h50);
        chk_bit(channel_irq, 1'b1);
        wr_reg(2'h3, 8'hFF);
        rd_chk(2'h3, 8'h00);
        rd_chk(TCC_OFS_STATUS_CONTROL, 8'hD0);
        @(posedge ref_clk);
        reset_n <= 1'b0;
        @(posedge ref_clk);
        #1;
        chk_bit(channel_irq, 1'b0);
        chk_bit(chan_pin_oe, 1'b0);
        repeat (2) @(posedge ref_clk);
        reset_n <= 1'b1;
        wr_reg(TCC_OFS_STATUS_CONTROL, 8'h80);
        rd_chk(TCC_OFS_STATUS_CONTROL, 8'h00);
        rd_chk(TCC_OFS_VALUE_HIGH, 8'h00);
        rd_chk(TCC_OFS_VALUE_LOW, 8'h00);
        wrap_up();
    end
endmodule : test_timer_channel_capture_compare
